// ==== inc/ssio_consts.vh ====
`ifndef SSIO_CONSTS_VH
`define SSIO_CONSTS_VH

// Register bus geometry
`define SSIO_ADDR_W 3
`define SSIO_DATA_W 8

// Register offsets
`define SSIO_OFS_PIN_LEVEL 3'h0
`define SSIO_OFS_LATCH 3'h1
`define SSIO_OFS_DIRECTION 3'h2
`define SSIO_OFS_SHARED_G 3'h3
`define SSIO_OFS_SEG_EN 3'h4

// Field positions
`define SSIO_PULLUP_BIT 7

// Reset values
`define SSIO_RST_LATCH 8'h00
`define SSIO_RST_DIRECTION 8'hff
`define SSIO_RST_PULLUP 1'h0
`define SSIO_RST_SEG_EN 8'h00
`define SSIO_RST_RDATA 8'h00

// Read value of unmapped offsets and unimplemented bits
`define SSIO_READ_ZERO 8'h00
`define SSIO_G_LOW_ZERO 7'h00

// Direction bit encoding
`define SSIO_DIR_OUTPUT 1'h0
`define SSIO_DIR_INPUT 1'h1

`endif

// ==== rtl/ssio_pin_cell.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ssio_consts.vh"

module ssio_pin_cell (
  input wire mclk,
  input wire arst_n,
  input wire latch_bit,
  input wire dir_bit,
  input wire pullup_global,
  input wire seg_bit,
  input wire pin_sync,
  output wire pin_read,
  output reg pin_out,
  output reg pin_oe,
  output reg pin_pullup,
  output reg seg_drive
);

  wire drive_next;
  wire pullup_next;

  // Segment ownership overrides the direction bit
  assign drive_next = !seg_bit && (dir_bit == `SSIO_DIR_OUTPUT);
  // Pull-up only on an input pin owned by the port
  assign pullup_next = pullup_global && !seg_bit && (dir_bit == `SSIO_DIR_INPUT);
  // A segment pin reads zero: port input is cut off
  assign pin_read = seg_bit ? 1'b0 : pin_sync;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      pin_pullup <= 1'b0;
      seg_drive <= 1'b0;
    end else begin
      pin_out <= drive_next ? latch_bit : 1'b0;
      pin_oe <= drive_next;
      pin_pullup <= pullup_next;
      seg_drive <= seg_bit;
    end
  end

endmodule // ssio_pin_cell

`default_nettype wire

// ==== rtl/ssio_port.v ====
// Functional notes
// - Eight pins with latch, direction, input bits
// - Direction 0 drives latch; 1 reads pin
// - Each pin's direction set independently
// - Reset sets all direction bits: inputs
// - Shared bit 7 enables all pull-ups
// - Output pins never get a pull-up
// - Pull-up enable clears on reset
// - Segment enable bit n selects pin n
// - Segment enable disables all pin I/O
// - Segment overrides the direction bit
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ssio_consts.vh"

module ssio_port #(
  parameter PINS = 8
) (
  input wire mclk,
  input wire arst_n,
  input wire [`SSIO_ADDR_W-1:0] reg_addr,
  input wire [`SSIO_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`SSIO_DATA_W-1:0] reg_rdata,
  input wire [PINS-1:0] io_pin_in,
  output wire [PINS-1:0] io_pin_out,
  output wire [PINS-1:0] io_pin_oe,
  output wire [PINS-1:0] io_pin_pullup,
  output wire [PINS-1:0] lcd_segment_output_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  reg [PINS-1:0] output_latch_reg;
  reg [PINS-1:0] output_latch_next;
  reg [PINS-1:0] direction_reg;
  reg [PINS-1:0] direction_next;
  reg port_pullup_enable_reg;
  reg port_pullup_enable_next;
  reg [PINS-1:0] segment_enable_low_reg;
  reg [PINS-1:0] segment_enable_low_next;
  reg [`SSIO_DATA_W-1:0] reg_rdata_next;

  wire [PINS-1:0] pin_sync;
  wire [PINS-1:0] pin_level;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire sel_pin_level;
  wire sel_latch;
  wire sel_direction;
  wire sel_shared_g;
  wire sel_seg_en;

  assign sel_pin_level = (reg_addr == `SSIO_OFS_PIN_LEVEL);
  assign sel_latch = (reg_addr == `SSIO_OFS_LATCH);
  assign sel_direction = (reg_addr == `SSIO_OFS_DIRECTION);
  assign sel_shared_g = (reg_addr == `SSIO_OFS_SHARED_G);
  assign sel_seg_en = (reg_addr == `SSIO_OFS_SEG_EN);

  ////////////////////////////////////////////////////////////////////////////
  // Output latch: written through either the port or the latch offset

  always @* begin
    output_latch_next = output_latch_reg;
    if (reg_wr && (sel_pin_level || sel_latch)) begin
      output_latch_next = reg_wdata[PINS-1:0];
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      output_latch_reg <= `SSIO_RST_LATCH;
    end else begin
      output_latch_reg <= output_latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction register, one bit per pin

  always @* begin
    direction_next = direction_reg;
    if (reg_wr && sel_direction) begin
      direction_next = reg_wdata[PINS-1:0];
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      direction_reg <= `SSIO_RST_DIRECTION;
    end else begin
      direction_reg <= direction_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared register: only the pull-up enable belongs to this port

  always @* begin
    port_pullup_enable_next = port_pullup_enable_reg;
    if (reg_wr && sel_shared_g) begin
      port_pullup_enable_next = reg_wdata[`SSIO_PULLUP_BIT];
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      port_pullup_enable_reg <= `SSIO_RST_PULLUP;
    end else begin
      port_pullup_enable_reg <= port_pullup_enable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment enable register

  always @* begin
    segment_enable_low_next = segment_enable_low_reg;
    if (reg_wr && sel_seg_en) begin
      segment_enable_low_next = reg_wdata[PINS-1:0];
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      segment_enable_low_reg <= `SSIO_RST_SEG_EN;
    end else begin
      segment_enable_low_reg <= segment_enable_low_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser

  ssio_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .async_in(io_pin_in),
    .sync_out(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin mux cells

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
      ssio_pin_cell u_cell (
        .mclk(mclk),
        .arst_n(arst_n),
        .latch_bit(output_latch_reg[gi]),
        .dir_bit(direction_reg[gi]),
        .pullup_global(port_pullup_enable_reg),
        .seg_bit(segment_enable_low_reg[gi]),
        .pin_sync(pin_sync[gi]),
        .pin_read(pin_level[gi]),
        .pin_out(io_pin_out[gi]),
        .pin_oe(io_pin_oe[gi]),
        .pin_pullup(io_pin_pullup[gi]),
        .seg_drive(lcd_segment_output_en[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data stand in the cycle after the strobe only

  always @* begin
    reg_rdata_next = `SSIO_READ_ZERO;
    if (reg_rd) begin
      if (sel_pin_level) begin
        reg_rdata_next = pin_level;
      end else if (sel_latch) begin
        reg_rdata_next = output_latch_reg;
      end else if (sel_direction) begin
        reg_rdata_next = direction_reg;
      end else if (sel_shared_g) begin
        reg_rdata_next = {port_pullup_enable_reg, `SSIO_G_LOW_ZERO};
      end else if (sel_seg_en) begin
        reg_rdata_next = segment_enable_low_reg;
      end else begin
        reg_rdata_next = `SSIO_READ_ZERO;
      end
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `SSIO_RST_RDATA;
    end else begin
      reg_rdata <= reg_rdata_next;
    end
  end

endmodule // ssio_port

`default_nettype wire

// ==== rtl/ssio_sync.v ====
`timescale 1ns/1ps
`default_nettype none

module ssio_sync #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire arst_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // First stage is read only by the second stage
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // ssio_sync

`default_nettype wire

// ==== rtl/ssio_unused_none.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/ssio_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssio_monitor #(parameter PINS = 8) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [PINS-1:0] io_pin_out,
  input wire logic [PINS-1:0] io_pin_oe,
  input wire logic [PINS-1:0] io_pin_pullup,
  input wire logic [PINS-1:0] lcd_segment_output_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire [PINS-1:0] sg = lcd_segment_output_en;
  property p_seg_oe; (sg & io_pin_oe) == 0; endproperty
  a_seg_oe: assert property (p_seg_oe) else $error("drive on segment pin");
  property p_seg_io; ((io_pin_out | io_pin_pullup) & sg) == 0; endproperty
  a_seg_io: assert property (p_seg_io) else $error("io on segment pin");
  property p_out_pu; (io_pin_oe & io_pin_pullup) == 0; endproperty
  a_out_pu: assert property (p_out_pu) else $error("pull-up on output");
  property p_out_oe; (io_pin_out & ~io_pin_oe) == 0; endproperty
  a_out_oe: assert property (p_out_oe) else $error("out without oe");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_unmap; reg_rd && reg_addr > 3'h4 |=> reg_rdata == 0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_g_low; reg_rd && reg_addr == 3'h3 |=> reg_rdata[6:0] == 0; endproperty
  a_g_low: assert property (p_g_low) else $error("shared low bits");
  property p_dir;
    reg_wr && reg_addr == 3'h2 |-> ##2 io_pin_oe == (~$past(reg_wdata, 2) & ~sg);
  endproperty
  a_dir: assert property (p_dir) else $error("direction write");
  property p_lat;
    reg_wr && reg_addr < 3'h2 |-> ##2 io_pin_out == ($past(reg_wdata, 2) & io_pin_oe);
  endproperty
  a_lat: assert property (p_lat) else $error("latch write");
  property p_seg; reg_wr && reg_addr == 3'h4 |-> ##2 sg == $past(reg_wdata, 2); endproperty
  a_seg: assert property (p_seg) else $error("segment write");
  property p_pu;
    reg_wr && reg_addr == 3'h3 |-> ##2
      io_pin_pullup == ({PINS{$past(reg_wdata, 2) > 8'h7f}} & ~io_pin_oe & ~sg);
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up write");
  c_seg: cover property (sg != 0);
  c_pu: cover property (io_pin_pullup != 0);
  c_rd: cover property (reg_rd ##1 reg_rdata != 0);
endmodule // ssio_monitor
bind ssio_port ssio_monitor #(.PINS(PINS)) ssio_monitor_i (.mclk(mclk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
  .io_pin_pullup(io_pin_pullup), .lcd_segment_output_en(lcd_segment_output_en));
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, io_pin_in = 0, rdata;
  wire [7:0] reg_rdata, io_pin_out, io_pin_oe, io_pin_pullup, lcd_segment_output_en;
  integer mismatches = 0, check_count = 0, lat, dir, pu, seg, i, a, d;
  always #25 mclk = ~mclk;
  ssio_port #(.PINS(8)) ssio_port_i (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
    .io_pin_pullup(io_pin_pullup), .lcd_segment_output_en(lcd_segment_output_en));
  ////////////////////////////////////////
  task cmp(input string n, input integer e, input logic [7:0] g);
    check_count++;
    if (g !== e[7:0]) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e[7:0], g);
    end
  endtask
  task xfer(input logic w, input logic [2:0] ad, input logic [7:0] dt);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge mclk);
    reg_wr <= 0;
    reg_rd <= 0;
    @(negedge mclk);
    rdata = reg_rdata;
  endtask
  task wr(input integer ad, input integer dt);
    xfer(1, ad[2:0], dt[7:0]);
    if (ad < 2) lat = dt;
    if (ad == 2) dir = dt;
    if (ad == 3) pu = dt >> 7;
    if (ad == 4) seg = dt;
  endtask
  task check_all;
    repeat (3) @(negedge mclk);
    cmp("oe", ~dir & ~seg, io_pin_oe);
    cmp("out", lat & ~dir & ~seg, io_pin_out);
    cmp("pullup", pu ? dir & ~seg : 0, io_pin_pullup);
    cmp("seg", seg, lcd_segment_output_en);
    for (a = 0; a < 8; a++) begin
      xfer(0, a[2:0], 8'h00);
      d = a == 0 ? io_pin_in & ~seg : a == 1 ? lat : a == 2 ? dir : 0;
      d = a == 3 ? pu << 7 : a == 4 ? seg : d;
      cmp("read", d, rdata);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    i = $urandom(32'hea39);
    lat = 0; dir = 255; pu = 0; seg = 0;
    repeat (10) @(posedge mclk);
    arst_n <= 1;
    check_all;
    wr(2, 8'h0f);
    wr(3, 8'h80);
    wr(0, 8'ha5);
    check_all;
    wr(4, 8'h81);
    check_all;
    for (i = 0; i < 30; i++) begin
      @(posedge mclk);
      io_pin_in <= $urandom;
      wr($urandom % 8, $urandom % 256);
      check_all;
    end
    wr(3, 8'h80);
    wr(4, 8'h03);
    wr(2, 8'hf0);
    wr(1, 8'hff);
    check_all;
    @(posedge mclk);
    arst_n <= 0;
    @(posedge mclk);
    arst_n <= 1;
    lat = 0; dir = 255; pu = 0; seg = 0;
    check_all;
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
